/* pkg/xsr_pkg.sv */
// Constants of the extended I/O signal router
package xsr_pkg;
    // Clock and time units
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MS_PS = 1000000000;
    localparam int MS_CYC = MS_PS / CLK_PERIOD_PS;
    localparam int TENTH_S_MS = 100;
    // APB register byte offsets
    localparam logic [7:0] OFS_SW_CFG = 8'h00;
    localparam logic [7:0] OFS_SW_TIME = 8'h04;
    localparam logic [7:0] OFS_DIFF_MODE = 8'h08;
    localparam logic [7:0] OFS_DIFF_A = 8'h0c;
    localparam logic [7:0] OFS_DIFF_B = 8'h10;
    localparam logic [7:0] OFS_VIN_CFG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // Field positions
    localparam int SW_INV_BIT = 8;
    localparam int SW_REL_LSB = 0;
    localparam int SW_DUR_LSB = 8;
    localparam int SW_LED_LSB = 16;
    localparam int DO_INV_BIT = 8;
    localparam int DO_DLY_LSB = 16;
    localparam int VIN_SRC_LSB = 8;
    localparam int VIN_INV_BIT = 16;
    localparam int VIN_ONE_BIT = 17;
    localparam int VIN_DEAD_LSB = 24;
    // Reset values
    localparam logic [7:0] RST_SW_FUNC = 8'h09;
    localparam logic [7:0] RST_SW_REL = 8'h0a;
    localparam logic [7:0] RST_SW_DUR = 8'h1e;
    localparam logic [7:0] RST_SW_LED = 8'h0a;
    localparam logic [7:0] RST_SIG_SEL = 8'h80;
    localparam logic [7:0] RST_VIN_FUNC = 8'h00;
    // Differential output modes
    localparam logic [7:0] MODE_NONE = 8'hff;
    localparam logic [7:0] MODE_AB = 8'h00;
    localparam logic [7:0] MODE_IO = 8'h08;
    // Special signal codes
    localparam logic [7:0] CODE_CONST_OFF = 8'h80;
    localparam logic [7:0] CODE_NO_FUNC = 8'h00;
endpackage

/* verilog/xsr_router.sv */
// Extended I/O signal router: panel switch, differential outputs, virtual input
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Switch drives selectable function, default code 9
// - Switch inversion setting flips the routed level
// - Hold switch for release time; zero disables
// - Stay released for set duration, then relock
// - Indicator lights for set time on input
// - Mode -1 off, 0 quadrature, 8 I/O status
// - I/O mode routes selected signal, default off
// - Per-output inversion of routed signal
// - Per-output off-delay up to 250 ms
// - Virtual input drives selected function; 0 none
// - Virtual input source selectable, default off
// - Virtual input source inversion setting
// - Virtual input on dead time up to 250 ms
// - One-shot setting gives pulse instead of level
module xsr_router #(
    parameter int MS_CYCLES = xsr_pkg::MS_CYC
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic PANEL_SWITCH_INPUT,
    input wire logic [255:0] INT_OUT_SIGNALS,
    input wire logic PHASE_A,
    input wire logic PHASE_B,
    output logic PANEL_SWITCH_LED,
    output logic [7:0] SWITCH_FUNC_CODE,
    output logic SWITCH_FUNC_ACTIVE,
    output logic DIFF_OUTPUT_FIRST,
    output logic DIFF_OUTPUT_SECOND,
    output logic DIFF_OE_N,
    output logic [7:0] SYNTHETIC_INPUT_ZERO_CODE,
    output logic SYNTHETIC_INPUT_ZERO
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Picks one signal; constant-off code always reads 0
    function automatic logic pick_sig(input logic [255:0] sigs,
                                      input logic [7:0] code);
        logic v;
        v = sigs[code];
        if (code == xsr_pkg::CODE_CONST_OFF) begin
            v = 1'b0;
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [7:0] sw_func_reg; // Function fed by the panel switch
    logic sw_inv_reg; // Switch inversion
    logic [7:0] sw_rel_reg; // Hold time to release, 0.1 s units
    logic [7:0] sw_dur_reg; // Time kept released, 0.1 s units
    logic [7:0] sw_led_reg; // Indicator on time, 0.1 s units
    logic [7:0] mode_reg; // Differential output mode
    logic [7:0] do_sel_reg [2]; // Routed signal per output
    logic do_inv_reg [2]; // Inversion per output
    logic [7:0] do_dly_reg [2]; // Off-delay per output, ms
    logic [7:0] vin_func_reg; // Function fed by the virtual input
    logic [7:0] vin_src_reg; // Trigger source of the virtual input
    logic vin_inv_reg; // Source inversion
    logic vin_one_reg; // One-shot enable
    logic [7:0] vin_dead_reg; // On dead time, ms

    logic wr_en; // Write taken this cycle
    logic rd_hit; // Address decodes to a register
    assign wr_en = PSEL && PENABLE && PWRITE && !PREADY;
    assign rd_hit = (PADDR == xsr_pkg::OFS_SW_CFG) ||
                    (PADDR == xsr_pkg::OFS_SW_TIME) ||
                    (PADDR == xsr_pkg::OFS_DIFF_MODE) ||
                    (PADDR == xsr_pkg::OFS_DIFF_A) ||
                    (PADDR == xsr_pkg::OFS_DIFF_B) ||
                    (PADDR == xsr_pkg::OFS_VIN_CFG) ||
                    (PADDR == xsr_pkg::OFS_STATUS);

    // Register writes; status is read only
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sw_func_reg <= xsr_pkg::RST_SW_FUNC;
            sw_inv_reg <= 1'b0;
            sw_rel_reg <= xsr_pkg::RST_SW_REL;
            sw_dur_reg <= xsr_pkg::RST_SW_DUR;
            sw_led_reg <= xsr_pkg::RST_SW_LED;
            mode_reg <= xsr_pkg::MODE_AB;
            do_sel_reg[0] <= xsr_pkg::RST_SIG_SEL;
            do_sel_reg[1] <= xsr_pkg::RST_SIG_SEL;
            do_inv_reg[0] <= 1'b0;
            do_inv_reg[1] <= 1'b0;
            do_dly_reg[0] <= 8'h00;
            do_dly_reg[1] <= 8'h00;
            vin_func_reg <= xsr_pkg::RST_VIN_FUNC;
            vin_src_reg <= xsr_pkg::RST_SIG_SEL;
            vin_inv_reg <= 1'b0;
            vin_one_reg <= 1'b0;
            vin_dead_reg <= 8'h00;
        end else if (wr_en) begin
            case (PADDR)
                xsr_pkg::OFS_SW_CFG: begin
                    sw_func_reg <= PWDATA[7:0];
                    sw_inv_reg <= PWDATA[xsr_pkg::SW_INV_BIT];
                end
                xsr_pkg::OFS_SW_TIME: begin
                    sw_rel_reg <= PWDATA[xsr_pkg::SW_REL_LSB +: 8];
                    sw_dur_reg <= PWDATA[xsr_pkg::SW_DUR_LSB +: 8];
                    sw_led_reg <= PWDATA[xsr_pkg::SW_LED_LSB +: 8];
                end
                xsr_pkg::OFS_DIFF_MODE: begin
                    mode_reg <= PWDATA[7:0];
                end
                xsr_pkg::OFS_DIFF_A: begin
                    do_sel_reg[0] <= PWDATA[7:0];
                    do_inv_reg[0] <= PWDATA[xsr_pkg::DO_INV_BIT];
                    do_dly_reg[0] <= PWDATA[xsr_pkg::DO_DLY_LSB +: 8];
                end
                xsr_pkg::OFS_DIFF_B: begin
                    do_sel_reg[1] <= PWDATA[7:0];
                    do_inv_reg[1] <= PWDATA[xsr_pkg::DO_INV_BIT];
                    do_dly_reg[1] <= PWDATA[xsr_pkg::DO_DLY_LSB +: 8];
                end
                xsr_pkg::OFS_VIN_CFG: begin
                    vin_func_reg <= PWDATA[7:0];
                    vin_src_reg <= PWDATA[xsr_pkg::VIN_SRC_LSB +: 8];
                    vin_inv_reg <= PWDATA[xsr_pkg::VIN_INV_BIT];
                    vin_one_reg <= PWDATA[xsr_pkg::VIN_ONE_BIT];
                    vin_dead_reg <= PWDATA[xsr_pkg::VIN_DEAD_LSB +: 8];
                end
                default: begin
                    // Unmapped or read-only: nothing stored
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state so that data and ready come from flops

    logic [31:0] rdata_next; // Read mux
    logic unlocked; // Interlock open, for status
    logic sw_sync2_reg; // Synchronised switch level

    // Read data mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (PADDR)
            xsr_pkg::OFS_SW_CFG:
                rdata_next = {23'h0, sw_inv_reg, sw_func_reg};
            xsr_pkg::OFS_SW_TIME:
                rdata_next = {8'h00, sw_led_reg, sw_dur_reg, sw_rel_reg};
            xsr_pkg::OFS_DIFF_MODE:
                rdata_next = {24'h0, mode_reg};
            xsr_pkg::OFS_DIFF_A:
                rdata_next = {8'h00, do_dly_reg[0], 7'h0, do_inv_reg[0],
                              do_sel_reg[0]};
            xsr_pkg::OFS_DIFF_B:
                rdata_next = {8'h00, do_dly_reg[1], 7'h0, do_inv_reg[1],
                              do_sel_reg[1]};
            xsr_pkg::OFS_VIN_CFG:
                rdata_next = {vin_dead_reg, 6'h0, vin_one_reg, vin_inv_reg,
                              vin_src_reg, vin_func_reg};
            xsr_pkg::OFS_STATUS:
                rdata_next = {26'h0, DIFF_OUTPUT_SECOND, DIFF_OUTPUT_FIRST,
                              SYNTHETIC_INPUT_ZERO, PANEL_SWITCH_LED,
                              unlocked, sw_sync2_reg};
            default:
                rdata_next = 32'h0000_0000;
        endcase
    end

    // Ready, read data and error, all registered
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0000_0000 : rdata_next;
            PSLVERR <= !rd_hit;
        end else begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time base: millisecond and tenth-second ticks

    logic [31:0] ms_cnt_reg; // Cycles within a millisecond
    logic [7:0] tenth_cnt_reg; // Milliseconds within 0.1 s
    logic ms_tick; // One cycle per millisecond
    logic tenth_tick; // One cycle per 0.1 s
    assign ms_tick = (ms_cnt_reg == 32'(MS_CYCLES - 1));
    assign tenth_tick = ms_tick &&
                        (tenth_cnt_reg == 8'(xsr_pkg::TENTH_S_MS - 1));

    // Free-running prescalers
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ms_cnt_reg <= 32'h0;
            tenth_cnt_reg <= 8'h00;
        end else begin
            ms_cnt_reg <= ms_tick ? 32'h0 : ms_cnt_reg + 32'h1;
            if (tenth_tick) begin
                tenth_cnt_reg <= 8'h00;
            end else if (ms_tick) begin
                tenth_cnt_reg <= tenth_cnt_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Panel switch: synchroniser, interlock, routing and indicator

    logic sw_sync1_reg; // First stage, read only by the second

    // Two-flop synchroniser for the asynchronous pin
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sw_sync1_reg <= 1'b0;
            sw_sync2_reg <= 1'b0;
        end else begin
            sw_sync1_reg <= PANEL_SWITCH_INPUT;
            sw_sync2_reg <= sw_sync1_reg;
        end
    end

    typedef enum logic [2:0] {
        ILK_LOCKED = 3'b001, // Counting hold time
        ILK_OPEN = 3'b010, // Released, counting duration
        ILK_WAIT = 3'b100 // Relocked, waiting for switch release
    } xsr_ilk_e;

    xsr_ilk_e ilk_reg; // Interlock state
    logic [7:0] hold_cnt_reg; // Held time, 0.1 s units
    logic [7:0] open_cnt_reg; // Open time left, 0.1 s

    // Interlock; a switch still held at relock must be let go first,
    // so a long press cannot chain open windows
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ilk_reg <= ILK_LOCKED;
            hold_cnt_reg <= 8'h00;
            open_cnt_reg <= 8'h00;
        end else begin
            case (ilk_reg)
                ILK_LOCKED: begin
                    if (!sw_sync2_reg) begin
                        hold_cnt_reg <= 8'h00;
                    end else if (hold_cnt_reg >= sw_rel_reg) begin
                        ilk_reg <= ILK_OPEN;
                        open_cnt_reg <= sw_dur_reg;
                    end else if (tenth_tick) begin
                        hold_cnt_reg <= hold_cnt_reg + 8'h01;
                    end
                end
                ILK_OPEN: begin
                    if (open_cnt_reg == 8'h00) begin
                        ilk_reg <= ILK_WAIT;
                        hold_cnt_reg <= 8'h00;
                    end else if (tenth_tick) begin
                        open_cnt_reg <= open_cnt_reg - 8'h01;
                    end
                end
                ILK_WAIT: begin
                    if (!sw_sync2_reg) begin
                        ilk_reg <= ILK_LOCKED;
                    end
                end
                default: begin
                    ilk_reg <= ILK_LOCKED;
                end
            endcase
        end
    end

    // Zero release time disables the interlock
    assign unlocked = (sw_rel_reg == 8'h00) || (ilk_reg == ILK_OPEN);

    logic [7:0] led_cnt_reg; // Indicator time left, 0.1 s
    logic sw_act_next; // Routed switch level

    assign sw_act_next = unlocked && (sw_sync2_reg ^ sw_inv_reg);

    // Routed switch function and its code
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SWITCH_FUNC_ACTIVE <= 1'b0;
            SWITCH_FUNC_CODE <= xsr_pkg::RST_SW_FUNC;
        end else begin
            SWITCH_FUNC_ACTIVE <= sw_act_next;
            SWITCH_FUNC_CODE <= sw_func_reg;
        end
    end

    // Indicator, restarted by each new routed assertion
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            led_cnt_reg <= 8'h00;
            PANEL_SWITCH_LED <= 1'b0;
        end else begin
            if (sw_act_next && !SWITCH_FUNC_ACTIVE) begin
                led_cnt_reg <= sw_led_reg;
            end else if (tenth_tick && led_cnt_reg != 8'h00) begin
                led_cnt_reg <= led_cnt_reg - 8'h01;
            end
            PANEL_SWITCH_LED <= (led_cnt_reg != 8'h00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Differential outputs

    logic [1:0] io_lvl; // Routed level with off-delay applied
    logic [7:0] off_cnt_reg [2]; // Off-delay left, ms

    // Routing, inversion and off-delay for each output
    for (genvar i = 0; i < 2; i++) begin : g_diff
        logic cond;
        assign cond = pick_sig(INT_OUT_SIGNALS, do_sel_reg[i])
                      ^ do_inv_reg[i];
        // Assertion passes at once; release waits out the delay
        always_ff @(posedge MCLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                off_cnt_reg[i] <= 8'h00;
            end else if (cond) begin
                off_cnt_reg[i] <= do_dly_reg[i];
            end else if (ms_tick && off_cnt_reg[i] != 8'h00) begin
                off_cnt_reg[i] <= off_cnt_reg[i] - 8'h01;
            end
        end
        assign io_lvl[i] = cond || (off_cnt_reg[i] != 8'h00);
    end

    // Output mode select; unknown codes behave as no output
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            DIFF_OUTPUT_FIRST <= 1'b0;
            DIFF_OUTPUT_SECOND <= 1'b0;
            DIFF_OE_N <= 1'b1;
        end else begin
            case (mode_reg)
                xsr_pkg::MODE_AB: begin
                    DIFF_OUTPUT_FIRST <= PHASE_A;
                    DIFF_OUTPUT_SECOND <= PHASE_B;
                    DIFF_OE_N <= 1'b0;
                end
                xsr_pkg::MODE_IO: begin
                    DIFF_OUTPUT_FIRST <= io_lvl[0];
                    DIFF_OUTPUT_SECOND <= io_lvl[1];
                    DIFF_OE_N <= 1'b0;
                end
                default: begin
                    DIFF_OUTPUT_FIRST <= 1'b0;
                    DIFF_OUTPUT_SECOND <= 1'b0;
                    DIFF_OE_N <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Virtual input

    logic vin_cond; // Selected and conditioned source
    logic [7:0] dead_cnt_reg; // Elapsed asserted time, ms
    logic vin_qual_reg; // Source survived the dead time
    logic vin_qual_next; // Next qualified level

    assign vin_cond = pick_sig(INT_OUT_SIGNALS, vin_src_reg)
                      ^ vin_inv_reg;
    assign vin_qual_next = vin_cond && (dead_cnt_reg >= vin_dead_reg);

    // Dead time: an early drop restarts the count
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dead_cnt_reg <= 8'h00;
            vin_qual_reg <= 1'b0;
        end else begin
            if (!vin_cond) begin
                dead_cnt_reg <= 8'h00;
            end else if (ms_tick && dead_cnt_reg < vin_dead_reg) begin
                dead_cnt_reg <= dead_cnt_reg + 8'h01;
            end
            vin_qual_reg <= vin_qual_next;
        end
    end

    // Level or single-cycle pulse; code 0 assigns no function
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            SYNTHETIC_INPUT_ZERO <= 1'b0;
            SYNTHETIC_INPUT_ZERO_CODE <= xsr_pkg::RST_VIN_FUNC;
        end else begin
            SYNTHETIC_INPUT_ZERO_CODE <= vin_func_reg;
            if (vin_func_reg == xsr_pkg::CODE_NO_FUNC) begin
                SYNTHETIC_INPUT_ZERO <= 1'b0;
            end else if (vin_one_reg) begin
                SYNTHETIC_INPUT_ZERO <= vin_qual_next && !vin_qual_reg;
            end else begin
                SYNTHETIC_INPUT_ZERO <= vin_qual_next;
            end
        end
    end

endmodule

`default_nettype wire

/* tb/xsr_router_asserts.sv */
// Port-level assertion checker for the signal router
`timescale 1ns/1ps
`default_nettype none
module xsr_router_asserts #(
    parameter int MS_CYCLES = 10
) (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic PHASE_A,
    input wire logic PHASE_B,
    input wire logic PANEL_SWITCH_LED,
    input wire logic [7:0] SWITCH_FUNC_CODE,
    input wire logic SWITCH_FUNC_ACTIVE,
    input wire logic DIFF_OUTPUT_FIRST,
    input wire logic DIFF_OUTPUT_SECOND,
    input wire logic DIFF_OE_N,
    input wire logic [7:0] SYNTHETIC_INPUT_ZERO_CODE,
    input wire logic SYNTHETIC_INPUT_ZERO
);
    ////////////////////////////////////////////////////////////////////////
    // Shadow settings, stored on the slave's write edge
    logic [7:0] mode_reg, mode_old_reg, func_reg, led_reg, vfunc_reg;
    logic one_reg;
    logic live_reg; // Masks first edge after reset
    logic take;
    assign take = PSEL && PENABLE && PWRITE && !PREADY;
    // Settings written by software
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_reg <= xsr_pkg::MODE_AB;
            func_reg <= xsr_pkg::RST_SW_FUNC;
            led_reg <= xsr_pkg::RST_SW_LED;
            vfunc_reg <= xsr_pkg::RST_VIN_FUNC;
            one_reg <= 1'b0;
        end else if (take) begin
            if (PADDR == xsr_pkg::OFS_DIFF_MODE) mode_reg <= PWDATA[7:0];
            if (PADDR == xsr_pkg::OFS_SW_CFG) func_reg <= PWDATA[7:0];
            if (PADDR == xsr_pkg::OFS_SW_TIME) led_reg <= PWDATA[23:16];
            if (PADDR == xsr_pkg::OFS_VIN_CFG)
                {one_reg, vfunc_reg} <= {PWDATA[17], PWDATA[7:0]};
        end
    end
    // Mode one cycle late, as the pins see it
    always_ff @(posedge MCLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mode_old_reg <= xsr_pkg::MODE_AB;
            live_reg <= 1'b0;
        end else begin
            mode_old_reg <= mode_reg;
            live_reg <= 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    sequence access_s;
        PSEL && PENABLE;
    endsequence
    wait_state_a: assert property (setup_s ##1 access_s |=> PREADY)
        else $error("no ready after wait state");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    slave_err_a: assert property (PREADY |->
        PSLVERR == (PADDR > 8'h18 || PADDR[1:0] != 2'b00))
        else $error("error flag wrong");
    ab_follow_a: assert property (live_reg && mode_reg == 8'h00 &&
        mode_old_reg == 8'h00 |-> DIFF_OUTPUT_FIRST == $past(PHASE_A) &&
        DIFF_OUTPUT_SECOND == $past(PHASE_B))
        else $error("pair not following phases");
    oe_mode_a: assert property (live_reg && mode_reg == mode_old_reg |->
        DIFF_OE_N == !(mode_reg == 8'h00 || mode_reg == 8'h08))
        else $error("pair enable wrong for mode");
    func_code_a: assert property (func_reg == $past(func_reg) |->
        SWITCH_FUNC_CODE == func_reg)
        else $error("switch function code wrong");
    vin_code_a: assert property (vfunc_reg == $past(vfunc_reg) |->
        SYNTHETIC_INPUT_ZERO_CODE == vfunc_reg)
        else $error("virtual input code wrong");
    one_shot_a: assert property (one_reg && $past(one_reg) &&
        SYNTHETIC_INPUT_ZERO |=> !SYNTHETIC_INPUT_ZERO)
        else $error("one-shot pulse too long");
    led_lit_a: assert property ($rose(SWITCH_FUNC_ACTIVE) &&
        led_reg != 8'h00 |-> ##[1:3] PANEL_SWITCH_LED)
        else $error("indicator not lit");
endmodule
bind xsr_router xsr_router_asserts #(.MS_CYCLES(MS_CYCLES)) chk_u (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PHASE_A(PHASE_A), .PHASE_B(PHASE_B),
    .PANEL_SWITCH_LED(PANEL_SWITCH_LED),
    .SWITCH_FUNC_CODE(SWITCH_FUNC_CODE),
    .SWITCH_FUNC_ACTIVE(SWITCH_FUNC_ACTIVE),
    .DIFF_OUTPUT_FIRST(DIFF_OUTPUT_FIRST),
    .DIFF_OUTPUT_SECOND(DIFF_OUTPUT_SECOND), .DIFF_OE_N(DIFF_OE_N),
    .SYNTHETIC_INPUT_ZERO_CODE(SYNTHETIC_INPUT_ZERO_CODE),
    .SYNTHETIC_INPUT_ZERO(SYNTHETIC_INPUT_ZERO));
`default_nettype wire

/* tb/xsr_far_end.sv */
// Far side: operator switch and pair receiver
`timescale 1ns/1ps
`default_nettype none
module xsr_far_end (
    input wire logic clk,
    input wire logic press,
    input wire logic oe_n,
    input wire logic dfirst,
    input wire logic dsecond,
    output logic switch_pin,
    output logic [1:0] rx_pair
);
    // Contact follows the operator
    always_ff @(posedge clk) begin
        switch_pin <= press;
    end
    // A released pair toggles every cycle instead of holding the last level
    always_ff @(posedge clk) begin
        if (!oe_n) begin
            rx_pair <= {dsecond, dfirst};
        end else begin
            rx_pair <= ~rx_pair;
        end
    end
endmodule
`default_nettype wire

/* tb/xsr_router_tb_top.sv */
// Self-checking bench of the signal router
`timescale 1ns/1ps
`default_nettype none
module xsr_router_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rnd = 32'h0, prdata;
    logic [255:0] noise = '0; // Random unused sources
    logic [2:0] ctl = 3'h0; // Sources 5, 6 and 7
    logic press = 1'b0, pha = 1'b0, phb = 1'b0, pready, pslverr, sw_pin;
    logic led, act, dfirst, dsecond, oe_n, vin;
    logic [7:0] fcode, vcode;
    logic [1:0] rx;
    logic [32:0] exp_q[$], msk_q[$], e, m;
    int seed = 16748, miscompares = 0, checked = 0, cyc = 0;
    wire logic [255:0] sigs = {noise[255:8], ctl, noise[4:0]};
    ////////////////////////////////////////////////////////////////////////
    xsr_router #(.MS_CYCLES(10)) dut_u (.MCLK(mclk), .SYS_RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PANEL_SWITCH_INPUT(sw_pin),
        .INT_OUT_SIGNALS(sigs), .PHASE_A(pha), .PHASE_B(phb),
        .PANEL_SWITCH_LED(led), .SWITCH_FUNC_CODE(fcode),
        .SWITCH_FUNC_ACTIVE(act), .DIFF_OUTPUT_FIRST(dfirst),
        .DIFF_OUTPUT_SECOND(dsecond), .DIFF_OE_N(oe_n),
        .SYNTHETIC_INPUT_ZERO_CODE(vcode), .SYNTHETIC_INPUT_ZERO(vin));
    xsr_far_end far_u (.clk(mclk), .press(press), .oe_n(oe_n),
        .dfirst(dfirst), .dsecond(dsecond), .switch_pin(sw_pin),
        .rx_pair(rx));
    // 200 MHz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    // Random stimulus and hang limit
    always @(posedge mclk) begin
        rnd = $random(seed);
        noise <= {8{rnd}};
        pha <= rnd[3];
        phb <= rnd[9];
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    // Watcher: oldest note against each read answer
    always @(posedge mclk) begin
        if (psel && penable && !pwrite && pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            checked++;
            if (({pslverr, prdata} & m) !== (e & m)) begin
                miscompares++;
                $display("wrong value at %0t: got %h expected %h", $time,
                    {pslverr, prdata} & m, e & m);
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // One bus transfer; waits for ready, then releases
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x,
        input logic [32:0] k);
        exp_q.push_back(x);
        msk_q.push_back(k);
        apb(1'b0, a, 32'h0);
    endtask
    // Status read; no error expected
    task automatic st(input logic [5:0] x, input logic [5:0] k);
        rd(xsr_pkg::OFS_STATUS, {27'h0, x}, {1'b1, 26'h0, k});
    endtask
    task automatic give_verdict();
        if (exp_q.size() != 0) miscompares++;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(8'h00, 33'h9, 33'h1ff);
        rd(8'h04, 33'ha1e0a, 33'hffffff);
        rd(8'h08, 33'h0, 33'hff);
        rd(8'h0c, 33'h80, 33'hff01ff);
        rd(8'h10, 33'h80, 33'hff01ff);
        rd(8'h14, 33'h8000, 33'hff03ffff);
        rd(8'h40, 33'h100000000, 33'h1ffffffff);
        repeat (30) @(posedge mclk);
        apb(1'b1, 8'h08, 32'hff);
        apb(1'b1, 8'h08, 32'h08);
        st(6'h00, 6'h30);
        ctl <= 3'b011;
        apb(1'b1, 8'h0c, 32'h30005);
        apb(1'b1, 8'h10, 32'h106);
        st(6'h10, 6'h30);
        ctl <= 3'b000;
        repeat (4) @(posedge mclk);
        st(6'h30, 6'h30);
        repeat (40) @(posedge mclk);
        st(6'h20, 6'h30);
        apb(1'b1, 8'h14, 32'h2000721);
        ctl <= 3'b100;
        repeat (8) @(posedge mclk);
        ctl <= 3'b000;
        st(6'h00, 6'h08);
        ctl <= 3'b100;
        repeat (40) @(posedge mclk);
        st(6'h08, 6'h08);
        apb(1'b1, 8'h14, 32'h2010721);
        st(6'h00, 6'h08);
        ctl <= 3'b000;
        apb(1'b1, 8'h14, 32'h20721);
        ctl <= 3'b100;
        repeat (10) @(posedge mclk);
        st(6'h00, 6'h08);
        apb(1'b1, 8'h04, 32'h20301);
        apb(1'b1, 8'h00, 32'h0b);
        press <= 1'b1;
        repeat (1100) @(posedge mclk);
        st(6'h03, 6'h03);
        repeat (4200) @(posedge mclk);
        st(6'h01, 6'h03);
        press <= 1'b0;
        repeat (6) @(posedge mclk);
        st(6'h00, 6'h03);
        apb(1'b1, 8'h04, 32'h20300);
        apb(1'b1, 8'h00, 32'h10b);
        repeat (6) @(posedge mclk);
        st(6'h04, 6'h05);
        give_verdict();
    end
endmodule
`default_nettype wire
